// ==== mcj_cond_eval.sv ====
// Instruction field decode and jump condition evaluation.
`timescale 1ns/1ps
module mcj_cond_eval (
	// Instruction in execution.
	input wire logic [mcj_pkg::INSTR_W-1:0] instr_word,
	// Context of the executing core.
	input wire logic core_id,
	input wire logic [mcj_pkg::START_W-1:0] start_latched,
	// Decode results.
	output logic is_rel_id,
	output logic is_far_start,
	output logic cond_true,
	output logic jump_reg_operand,
	output logic [mcj_pkg::OFFS_W-1:0] rel_offset
);
	import mcj_pkg::*;

	logic core_select_operand;
	logic core_zero_selected;
	logic core_one_selected;
	logic [START_W-1:0] start_set_selector;
	logic [START_W-1:0] bit_match;
	logic start_match;

	// Opcode recognition for both instructions.
	assign is_rel_id = (instr_word[REL_OPC_HI:REL_OPC_LO] == REL_OPC);
	assign is_far_start = (instr_word[FAR_OPC_HI:FAR_OPC_LO] == FAR_OPC) &&
		(instr_word[FAR_TAIL_HI:FAR_TAIL_LO] == FAR_TAIL);

	// Operand fields; each is meaningful only under its own opcode.
	assign core_select_operand = instr_word[REL_CORE_SEL_BIT];
	assign rel_offset = instr_word[REL_OFFS_HI:REL_OFFS_LO];
	assign start_set_selector = instr_word[FAR_SEL_HI:FAR_SEL_LO];
	assign jump_reg_operand = instr_word[FAR_REG_BIT];

	// Core identity condition: selector 0 holds on core 0 only, 1 on core 1 only.
	assign core_zero_selected = (core_select_operand == CORE_SEL_ZERO) && (core_id == 1'b0);
	assign core_one_selected = (core_select_operand == CORE_SEL_ONE) && (core_id == 1'b1);

	// Exact set match, one comparator per start input; zero code means no start latched.
	genvar gi;
	generate
		for (gi = 0; gi < START_W; gi++) begin : g_start
			assign bit_match[gi] = (start_set_selector[gi] == start_latched[gi]);
		end
	endgenerate
	assign start_match = &bit_match;

	// Condition of whichever jump is decoded.
	assign cond_true = is_rel_id ? (core_zero_selected | core_one_selected) :
		(is_far_start & start_match);
endmodule

// ==== mcj_jump_decode.sv ====
// Program counter update for the core-identity relative jump and start-condition far jump.
// Notes on behaviour
// - Relative identity jump: bits 15..6 are 0010111101, bit 5 selector, bits 4..0 offset.
// - Selector 0 is true only on core 0; selector 1 only on core 1.
// - Taken relative jump loads the jump's own address plus the extended offset.
// - Offset is 5-bit two's complement, range -16 to 15.
// - Taken far jump loads the named jump register.
// - Far jump target is absolute, any Code RAM address, no arithmetic.
// - Start selector is a set, bit 0 start 1; holds when equal to latched set.
// - Far jump: bits 15..11 are 00111, bits 3..0 are 0001, selector between.
`timescale 1ns/1ps
module mcj_jump_decode (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Instruction execution.
	input wire logic instr_valid,
	input wire logic [mcj_pkg::INSTR_W-1:0] instr_word,
	// Core context.
	input wire logic core_id,
	input wire logic [mcj_pkg::START_W-1:0] start_latched,
	// Jump register subset.
	input wire logic [mcj_pkg::ADDR_W-1:0] jump_reg0,
	input wire logic [mcj_pkg::ADDR_W-1:0] jump_reg1,
	// Results.
	output logic [mcj_pkg::ADDR_W-1:0] core_program_counter,
	output logic jump_taken,
	output logic jump_decoded
);
	import mcj_pkg::*;

	logic is_rel_id;
	logic is_far_start;
	logic cond_true;
	logic jump_reg_operand;
	logic [OFFS_W-1:0] rel_offset;
	logic [ADDR_W-1:0] offset_ext;
	logic [ADDR_W-1:0] far_target;
	mcj_pc_sel_t pc_sel;
	logic [ADDR_W-1:0] pc_r;
	logic [ADDR_W-1:0] pc_nxt;
	logic taken_r;
	logic taken_nxt;
	logic decoded_r;
	logic decoded_nxt;

	mcj_cond_eval u_cond (
		.instr_word(instr_word),
		.core_id(core_id),
		.start_latched(start_latched),
		.is_rel_id(is_rel_id),
		.is_far_start(is_far_start),
		.cond_true(cond_true),
		.jump_reg_operand(jump_reg_operand),
		.rel_offset(rel_offset)
	);

	// Sign extension keeps backward jumps in range; the sum wraps within Code RAM.
	assign offset_ext = {{(ADDR_W-OFFS_W){rel_offset[OFFS_W-1]}}, rel_offset};

	// Target comes straight from the register, full width, so any location is reachable.
	assign far_target = jump_reg_operand ? jump_reg1 : jump_reg0;

	// Choose how the counter moves for the instruction in execution.
	always_comb begin
		if (is_rel_id && cond_true) begin
			pc_sel = MCJ_PC_REL;
		end else if (is_far_start && cond_true) begin
			pc_sel = MCJ_PC_FAR;
		end else begin
			pc_sel = MCJ_PC_SEQ;
		end
	end

	// Next counter and status values; nothing moves without an executing instruction.
	always_comb begin
		pc_nxt = pc_r;
		taken_nxt = 1'b0;
		decoded_nxt = 1'b0;
		if (instr_valid) begin
			decoded_nxt = is_rel_id | is_far_start;
			unique case (pc_sel)
				MCJ_PC_REL: begin
					pc_nxt = ADDR_W'(pc_r + offset_ext);
					taken_nxt = 1'b1;
				end
				MCJ_PC_FAR: begin
					pc_nxt = far_target;
					taken_nxt = 1'b1;
				end
				MCJ_PC_SEQ: begin
					pc_nxt = ADDR_W'(pc_r + PC_STEP);
				end
			endcase
		end
	end

	// Registered state.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pc_r <= PC_RESET;
			taken_r <= 1'b0;
			decoded_r <= 1'b0;
		end else begin
			pc_r <= pc_nxt;
			taken_r <= taken_nxt;
			decoded_r <= decoded_nxt;
		end
	end

	assign core_program_counter = pc_r;
	assign jump_taken = taken_r;
	assign jump_decoded = decoded_r;
endmodule

// ==== mcj_jump_decode_chk.sv ====
// Port assertions for the conditional jump decode block.
`timescale 1ns/1ps
module mcj_jump_decode_chk import mcj_pkg::*; (
	// Clock, reset and stimulus.
	input wire logic core_clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [INSTR_W-1:0] instr_word,
	input wire logic core_id,
	input wire logic [START_W-1:0] start_latched,
	input wire logic [ADDR_W-1:0] jump_reg0,
	input wire logic [ADDR_W-1:0] jump_reg1,
	// Results.
	input wire logic [ADDR_W-1:0] core_program_counter,
	input wire logic jump_taken,
	input wire logic jump_decoded
);
	logic rel;
	logic far;
	// Decoded here so that the properties stay short.
	assign rel = instr_valid && instr_word[15:6] == REL_OPC;
	assign far = instr_valid && instr_word[15:11] == FAR_OPC && instr_word[3:0] == FAR_TAIL;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_rel_taken: assert property (rel && instr_word[5] == core_id |=> jump_taken && core_program_counter ==
		$past(core_program_counter) + {{5{$past(instr_word[4])}}, $past(instr_word[4:0])}) else $error("rel target");
	chk_rel_skip: assert property (rel && instr_word[5] != core_id |=> !jump_taken) else $error("rel skip");
	chk_far_taken: assert property (far && instr_word[10:5] == start_latched |=> jump_taken &&
		core_program_counter == ($past(instr_word[4]) ? $past(jump_reg1) : $past(jump_reg0))) else $error("far target");
	chk_far_skip: assert property (far && instr_word[10:5] != start_latched |=> !jump_taken) else $error("far skip");
	chk_step_on: assert property (instr_valid && !jump_taken ##1 !jump_taken |->
		core_program_counter == $past(core_program_counter) + PC_STEP || !$past(instr_valid)) else $error("step");
	chk_decoded: assert property (rel || far |=> jump_decoded) else $error("decode pulse");
	chk_no_decode: assert property (instr_valid && !rel && !far |=> !jump_decoded && !jump_taken) else $error("decode");
	chk_idle_hold: assert property (!instr_valid |=> $stable(core_program_counter) && !jump_decoded) else $error("idle");
endmodule
bind mcj_jump_decode mcj_jump_decode_chk u_chk (
	.core_clk(core_clk),
	.rst(rst),
	.instr_valid(instr_valid),
	.instr_word(instr_word),
	.core_id(core_id),
	.start_latched(start_latched),
	.jump_reg0(jump_reg0),
	.jump_reg1(jump_reg1),
	.core_program_counter(core_program_counter),
	.jump_taken(jump_taken),
	.jump_decoded(jump_decoded)
);

// ==== mcj_jump_decode_tb.sv ====
// Self-checking bench for the conditional jump decode block.
`timescale 1ns/1ps
module mcj_jump_decode_tb;
	import mcj_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	logic [INSTR_W-1:0] instr_word = 16'h0000;
	logic core_id = 1'b0;
	logic [START_W-1:0] start_latched = 6'h00;
	logic [ADDR_W-1:0] jump_reg0 = 10'h3ff;
	logic [ADDR_W-1:0] jump_reg1 = 10'h2a5;
	logic [ADDR_W-1:0] core_program_counter;
	logic jump_taken;
	logic jump_decoded;
	logic [ADDR_W-1:0] pc = PC_RESET;
	int fail_count = 0;
	int n_compared = 0;
	mcj_jump_decode dut (
		.core_clk(core_clk),
		.rst(rst),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.core_id(core_id),
		.start_latched(start_latched),
		.jump_reg0(jump_reg0),
		.jump_reg1(jump_reg1),
		.core_program_counter(core_program_counter),
		.jump_taken(jump_taken),
		.jump_decoded(jump_decoded)
	);
	// Clock at 200 MHz.
	always #2.5 core_clk = ~core_clk;
	// Compares one result; case equality keeps unknowns from passing.
	task automatic compare(input string what, input logic [9:0] exp, input logic [9:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Executes one word, leaving an idle cycle after it, and checks the outcome.
	task automatic exec(input logic [15:0] w, input logic cid, input logic [5:0] st, input logic [9:0] tgt,
		input logic tk, input logic dc);
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		core_id <= cid;
		start_latched <= st;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		compare("counter", tgt, core_program_counter);
		compare("pulses", {8'h00, tk, dc}, {8'h00, jump_taken, jump_decoded});
		pc = tgt;
	endtask
	// Both selectors on both cores, at the offset extremes; -16 from 15 wraps below zero.
	task automatic t_rel();
		logic [4:0] off;
		for (int i = 0; i < 8; i++) begin
			off = i[0] ? 5'h10 : 5'h0f;
			exec({REL_OPC, i[1], off}, i[2], 6'h00, i[1] == i[2] ? pc + {{5{off[4]}}, off} : pc + PC_STEP,
				i[1] == i[2], 1'b1);
		end
		$display("test t_rel done");
	endtask
	// Boundary start sets, matched then missed by one start, through both registers.
	task automatic t_far();
		logic [5:0] sel [5] = '{6'h00, 6'h01, 6'h20, 6'h3f, 6'h15};
		logic [5:0] s;
		for (int i = 0; i < 10; i++) begin
			s = sel[i % 5];
			exec({FAR_OPC, s, i[0], FAR_TAIL}, 1'b0, i < 5 ? s : s ^ 6'h01, i < 5 ? (i[0] ? jump_reg1 : jump_reg0) :
				pc + PC_STEP, i < 5, 1'b1);
		end
		$display("test t_far done");
	endtask
	// Near-miss words only step; idle cycles leave the counter alone.
	task automatic t_other();
		exec(16'h3800, 1'b0, 6'h00, pc + PC_STEP, 1'b0, 1'b0);
		exec(16'h2f80, 1'b1, 6'h00, pc + PC_STEP, 1'b0, 1'b0);
		repeat (3) @(posedge core_clk);
		#1;
		compare("idle", pc, core_program_counter);
		$display("test t_other done");
	endtask
	// Back-to-back words: the second must start from the address the first jumped to.
	task automatic t_burst();
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_word <= {REL_OPC, 1'b1, 5'h03};
		core_id <= 1'b1;
		@(posedge core_clk);
		instr_word <= 16'h3800;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		compare("burst counter", pc + 10'h004, core_program_counter);
		compare("burst pulses", 10'h000, {8'h00, jump_taken, jump_decoded});
		pc = pc + 10'h004;
		$display("test t_burst done");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		compare("reset", PC_RESET, core_program_counter);
		t_rel();
		t_far();
		t_other();
		t_burst();
		results();
	end
endmodule

// ==== mcj_pkg.sv ====
// Constants shared by the conditional jump decode block.
package mcj_pkg;

	// Word and address widths.
	localparam int INSTR_W = 16;
	localparam int ADDR_W = 10;
	localparam int START_W = 6;
	localparam int OFFS_W = 5;

	// Program counter value after reset and its sequential step.
	localparam logic [ADDR_W-1:0] PC_RESET = 10'h000;
	localparam logic [ADDR_W-1:0] PC_STEP = 10'h001;

	// Relative core-identity jump: fixed pattern in bits 15..6.
	localparam int REL_OPC_HI = 15;
	localparam int REL_OPC_LO = 6;
	localparam logic [9:0] REL_OPC = 10'h0bd;
	localparam int REL_CORE_SEL_BIT = 5;
	localparam int REL_OFFS_HI = 4;
	localparam int REL_OFFS_LO = 0;

	// Start-condition far jump: bits 15..11 and 3..0 fixed.
	localparam int FAR_OPC_HI = 15;
	localparam int FAR_OPC_LO = 11;
	localparam logic [4:0] FAR_OPC = 5'h07;
	localparam int FAR_SEL_HI = 10;
	localparam int FAR_SEL_LO = 5;
	localparam int FAR_REG_BIT = 4;
	localparam int FAR_TAIL_HI = 3;
	localparam int FAR_TAIL_LO = 0;
	localparam logic [3:0] FAR_TAIL = 4'h1;

	// Core selector encodings.
	localparam logic CORE_SEL_ZERO = 1'b0;
	localparam logic CORE_SEL_ONE = 1'b1;

	// Program counter update kinds.
	typedef enum logic [2:0] {
		MCJ_PC_SEQ = 3'b001,
		MCJ_PC_REL = 3'b010,
		MCJ_PC_FAR = 3'b100
	} mcj_pc_sel_t;

endpackage
